// ===== hdl/flc_top.v
// fuse application and section lock logic of the nonvolatile memory
// assumes synchronous inputs and a single-cycle register port
//
// What this block does
// - after reset release, hold internal reset for delay counted in slow oscillator cycles
// - delay code 00 is 64 cycles, 01 is 4, 11 none, 10 reserved
// - changed fuse byte 4 never reads back: reset reloads FF before the copy is latched, latched value reported; fuse byte 5 reads back at once
// - watchdog lock fuse at 0 freezes config, forces enable, ignores clears
// - watchdog lock never sets window mode; software sets it itself
// - active brownout mode: 01 sampled, 10 continuous, 11 off, 00 reserved
// - chip erase clears flash; eeprom kept when keep fuse is 0
// - new eeprom keep fuse value governs chip erase immediately after write
// - fuse bits 2:0 select brownout trip threshold
// - boot section lock bits 7:6 only tighten on write
// - application lock bits 5:4 only tighten; chip erase or reset unlocks
// - boot lock 11 free access; 10 rejects stores to boot section
// - boot lock 01 blocks cross loads of boot; masks interrupts conditionally
// - boot lock 00 blocks stores and cross loads, masks interrupts
// - app lock 11 unrestricted; 10 rejects stores to application section
// - app lock 01 blocks cross loads of application; masks interrupts conditionally
// - app lock 00 blocks stores and cross loads, masks interrupts
// - external lock bits writable only by external programmer; erase clears
//
// The strobed register port was chosen for this implementation.
`include "flc_regs.vh"
`timescale 1ns/100ps
`default_nettype none

module flc_top #(
   parameter [17:0] SLOW_TICK = `FLC_SLOW_TICK_CYC
) (
   // clock and reset
   input  wire       CLK,
   input  wire       SRST,
   // register port
   input  wire [3:0] ADDR,
   input  wire [7:0] WDATA,
   input  wire       WR,
   input  wire       RD,
   output reg  [7:0] RDATA,
   // program memory access check
   input  wire       PM_STORE,
   input  wire       PM_LOAD,
   input  wire       PM_TGT_BOOT,
   input  wire       PM_EXEC_BOOT,
   input  wire       VEC_IN_BOOT,
   output reg        PM_STORE_OK,
   output reg        PM_LOAD_OK,
   output reg        INT_MASK,
   // system outputs
   output reg        INT_RESET,
   output reg  [1:0] BOD_ACTIVE_MODE,
   output reg  [2:0] BOD_THRESHOLD,
   output reg        ERASE_FLASH,
   output reg        ERASE_EEPROM,
   output reg        WDOG_ENABLE,
   output reg        WDOG_WINDOW
);

   // raw fuse storage and working copies
   reg  [7:0]  fuse4;
   reg  [7:0]  fuse5;
   reg  [7:0]  lock;
   reg  [1:0]  startup_delay_sel;
   reg         wdog_cfg_lock;
   reg  [1:0]  brownout_active_mode;
   reg  [2:0]  brownout_threshold_sel;
   reg         ext_prog;
   reg  [17:0] tick_cnt;
   reg  [6:0]  delay_cnt;
   reg         wdog_en;
   reg         wdog_win;
   reg         latched;
   reg         last_denied;

   // tighten-only merge of a two-bit lock field
   function [1:0] tighten;
      input [1:0] cur;
      input [1:0] req;
      begin
         tighten = cur & req;
      end
   endfunction

   // delay count from selector
   function [6:0] sut_cycles;
      input [1:0] sel;
      begin
         case (sel)
            `FLC_SUT_LONG:  sut_cycles = `FLC_SUT_LONG_CYC;
            `FLC_SUT_SHORT: sut_cycles = `FLC_SUT_SHORT_CYC;
            default:        sut_cycles = 7'd0;
         endcase
      end
   endfunction

   wire [1:0] boot_section_lock = lock[`FLC_LK_BOOT_HI:`FLC_LK_BOOT_LO];
   wire [1:0] app_section_lock  = lock[`FLC_LK_APP_HI:`FLC_LK_APP_LO];
   wire       erase_req = WR && (ADDR == `FLC_OFS_CTRL) && WDATA[`FLC_CTRL_ERASE];

   // fuse and lock storage
   always @(posedge CLK) begin
      if (SRST) begin
         fuse4    <= `FLC_RST_FUSE4;
         fuse5    <= `FLC_RST_FUSE5;
         lock     <= `FLC_RST_LOCK;
         ext_prog <= 1'b0;
      end else begin
         if (WR && ADDR == `FLC_OFS_CTRL)
            ext_prog <= WDATA[`FLC_CTRL_EXTPROG];
         if (erase_req) begin
            lock <= `FLC_RST_LOCK;
         end else if (WR && ADDR == `FLC_OFS_LOCK) begin
            lock[7:6] <= tighten(lock[7:6], WDATA[7:6]);
            lock[5:4] <= tighten(lock[5:4], WDATA[5:4]);
            lock[3:2] <= tighten(lock[3:2], WDATA[3:2]);
            if (ext_prog)
               lock[1:0] <= tighten(lock[1:0], WDATA[1:0]);
         end
         if (WR && ADDR == `FLC_OFS_FUSE4)
            fuse4 <= WDATA;
         if (WR && ADDR == `FLC_OFS_FUSE5)
            fuse5 <= WDATA | `FLC_F5_RSVD_MASK;
      end
   end

   // working copies, taken once in the first cycle after reset release
   always @(posedge CLK) begin
      if (SRST) begin
         latched <= 1'b0;
      end else if (!latched) begin
         latched                <= 1'b1;
         startup_delay_sel      <= fuse4[`FLC_F4_STARTUP_HI:`FLC_F4_STARTUP_LO];
         wdog_cfg_lock          <= fuse4[`FLC_F4_WDOG_CFG_LOCK];
         brownout_active_mode   <= fuse5[`FLC_F5_BOD_ACT_HI:`FLC_F5_BOD_ACT_LO];
         brownout_threshold_sel <= fuse5[`FLC_F5_THR_HI:`FLC_F5_THR_LO];
      end
   end

   // start-up delay on slow oscillator ticks
   always @(posedge CLK) begin
      if (SRST) begin
         tick_cnt  <= 18'h0_0000;
         delay_cnt <= 7'h00;
         INT_RESET <= 1'b1;
      end else if (!latched) begin
         tick_cnt  <= 18'h0_0000;
         delay_cnt <= sut_cycles(fuse4[`FLC_F4_STARTUP_HI:`FLC_F4_STARTUP_LO]);
         INT_RESET <= 1'b1;
      end else if (delay_cnt == 7'h00) begin
         INT_RESET <= 1'b0;
      end else if (tick_cnt == SLOW_TICK - 18'd1) begin
         tick_cnt  <= 18'h0_0000;
         delay_cnt <= delay_cnt - 7'd1;
      end else begin
         tick_cnt <= tick_cnt + 18'd1;
      end
   end

   // watchdog configuration
   always @(posedge CLK) begin
      if (SRST || !latched) begin
         wdog_en  <= 1'b0;
         wdog_win <= 1'b0;
      end else if (!wdog_cfg_lock) begin
         wdog_en <= 1'b1;
      end else if (WR && ADDR == `FLC_OFS_WDOG) begin
         wdog_en  <= WDATA[`FLC_WDOG_EN];
         wdog_win <= WDATA[`FLC_WDOG_WIN];
      end
   end

   // access checks
   reg next_store_ok;
   reg next_load_ok;
   reg next_mask;
   always @* begin
      next_store_ok = 1'b1;
      next_load_ok  = 1'b1;
      next_mask     = 1'b0;
      if (PM_TGT_BOOT) begin
         if (!boot_section_lock[0])
            next_store_ok = 1'b0;
         if (!boot_section_lock[1] && !PM_EXEC_BOOT)
            next_load_ok = 1'b0;
      end else begin
         if (!app_section_lock[0])
            next_store_ok = 1'b0;
         if (!app_section_lock[1] && PM_EXEC_BOOT)
            next_load_ok = 1'b0;
      end
      if (PM_EXEC_BOOT && !VEC_IN_BOOT && !boot_section_lock[1])
         next_mask = 1'b1;
      if (!PM_EXEC_BOOT && VEC_IN_BOOT && !app_section_lock[1])
         next_mask = 1'b1;
   end

   // registered outputs
   always @(posedge CLK) begin
      if (SRST) begin
         PM_STORE_OK     <= 1'b0;
         PM_LOAD_OK      <= 1'b0;
         INT_MASK        <= 1'b0;
         BOD_ACTIVE_MODE <= `FLC_BOD_OFF;
         BOD_THRESHOLD   <= 3'h7;
         ERASE_FLASH     <= 1'b0;
         ERASE_EEPROM    <= 1'b0;
         WDOG_ENABLE     <= 1'b0;
         WDOG_WINDOW     <= 1'b0;
         last_denied     <= 1'b0;
         RDATA           <= 8'h00;
      end else begin
         PM_STORE_OK     <= PM_STORE && next_store_ok;
         PM_LOAD_OK      <= PM_LOAD && next_load_ok;
         INT_MASK        <= next_mask;
         BOD_ACTIVE_MODE <= latched ? brownout_active_mode : `FLC_BOD_OFF;
         BOD_THRESHOLD   <= latched ? brownout_threshold_sel : 3'h7;
         ERASE_FLASH     <= erase_req;
         ERASE_EEPROM    <= erase_req && fuse5[`FLC_F5_EEKEEP];
         WDOG_ENABLE     <= wdog_en;
         WDOG_WINDOW     <= wdog_win;
         if ((PM_STORE && !next_store_ok) || (PM_LOAD && !next_load_ok))
            last_denied <= 1'b1;
         else if (RD && ADDR == `FLC_OFS_STATUS)
            last_denied <= 1'b0;
         RDATA <= 8'h00;
         if (RD) begin
            case (ADDR)
               `FLC_OFS_FUSE4:  RDATA <= {4'hF, startup_delay_sel, wdog_cfg_lock, 1'b1};
               `FLC_OFS_FUSE5:  RDATA <= fuse5;
               `FLC_OFS_LOCK:   RDATA <= lock;
               `FLC_OFS_CTRL:   RDATA <= {6'h00, ext_prog, 1'b0};
               `FLC_OFS_STATUS: RDATA <= {5'h00, last_denied, INT_RESET, latched};
               `FLC_OFS_WDOG:   RDATA <= {6'h00, wdog_win, wdog_en};
               default:         RDATA <= 8'h00;
            endcase
         end
      end
   end

endmodule // flc_top
`default_nettype wire

// ===== hdl/flc_regs.vh
// constants for the fuse and lock configuration block
// assumes inclusion by hdl/flc_top.v only
`ifndef FLC_REGS_VH
`define FLC_REGS_VH

// register offsets
`define FLC_OFS_FUSE4       4'h4
`define FLC_OFS_FUSE5       4'h5
`define FLC_OFS_LOCK        4'h7
`define FLC_OFS_CTRL        4'h8
`define FLC_OFS_STATUS      4'h9
`define FLC_OFS_WDOG        4'hA

// reset values
`define FLC_RST_FUSE4       8'hFF
`define FLC_RST_FUSE5       8'hFF
`define FLC_RST_LOCK        8'hFF

// fuse byte 4 fields
`define FLC_F4_STARTUP_HI   3
`define FLC_F4_STARTUP_LO   2
`define FLC_F4_WDOG_CFG_LOCK       1
// fuse byte 5 fields
`define FLC_F5_BOD_ACT_HI   5
`define FLC_F5_BOD_ACT_LO   4
`define FLC_F5_EEKEEP       3
`define FLC_F5_THR_HI       2
`define FLC_F5_THR_LO       0
`define FLC_F5_RSVD_MASK    8'hC0
// lock fields
`define FLC_LK_BOOT_HI      7
`define FLC_LK_BOOT_LO      6
`define FLC_LK_APP_HI       5
`define FLC_LK_APP_LO       4
`define FLC_LK_TBL_HI       3
`define FLC_LK_TBL_LO       2
`define FLC_LK_EXT_HI       1
`define FLC_LK_EXT_LO       0

// control and watchdog register bits
`define FLC_CTRL_ERASE      0
`define FLC_CTRL_EXTPROG    1
`define FLC_WDOG_EN         0
`define FLC_WDOG_WIN        1

// start-up delay codes and counts in slow-oscillator cycles
`define FLC_SUT_LONG        2'b00
`define FLC_SUT_SHORT       2'b01
`define FLC_SUT_NONE        2'b11
`define FLC_SUT_LONG_CYC    7'd64
`define FLC_SUT_SHORT_CYC   7'd4

// slow oscillator period and 200 MHz clock period
`define FLC_SLOW_PERIOD_NS  1000000
`define FLC_CLK_PERIOD_NS   5
`define FLC_SLOW_TICK_CYC   18'd200000

// brownout operating modes
`define FLC_BOD_SAMPLED     2'b01
`define FLC_BOD_CONT        2'b10
`define FLC_BOD_OFF         2'b11

`endif

// ===== test/flc_chk.sv
// checker: port relations of the fuse and lock block
// assumes bind onto flc_top, single clock domain
`timescale 1ns/100ps
`default_nettype none
module flc_chk (
   // clock, reset, bus
   input wire logic       CLK,
   input wire logic       SRST,
   input wire logic [3:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic       WR,
   // access check
   input wire logic       PM_STORE,
   input wire logic       PM_LOAD,
   input wire logic       PM_TGT_BOOT,
   input wire logic       PM_EXEC_BOOT,
   input wire logic       VEC_IN_BOOT,
   input wire logic       PM_STORE_OK,
   input wire logic       PM_LOAD_OK,
   input wire logic       INT_MASK,
   // system
   input wire logic       ERASE_FLASH,
   input wire logic       ERASE_EEPROM,
   input wire logic [1:0] BOD_ACTIVE_MODE,
   input wire logic [2:0] BOD_THRESHOLD,
   input wire logic       WDOG_WINDOW
);
   default clocking @(posedge CLK); endclocking
   default disable iff (SRST);
   a_store_cause: assert property (!$past(PM_STORE) |-> !PM_STORE_OK)
      else $error("store granted without request");
   a_load_cause: assert property (!$past(PM_LOAD) |-> !PM_LOAD_OK)
      else $error("load granted without request");
   a_load_same: assert property ($past(PM_LOAD && PM_TGT_BOOT == PM_EXEC_BOOT) |-> PM_LOAD_OK)
      else $error("same section load refused");
   a_mask_cross: assert property (INT_MASK |-> $past(PM_EXEC_BOOT != VEC_IN_BOOT))
      else $error("interrupt mask without cross section");
   a_erase_pair: assert property (ERASE_EEPROM |-> ERASE_FLASH)
      else $error("eeprom erase alone");
   a_erase_pulse: assert property (ERASE_FLASH |=> !ERASE_FLASH)
      else $error("erase pulse too long");
   a_erase_src: assert property (ERASE_FLASH |-> $past(WR && ADDR == 4'h8 && WDATA[0]))
      else $error("erase without command");
   a_bod_legal: assert property (BOD_ACTIVE_MODE != 2'b00)
      else $error("brownout mode reserved");
   a_bod_held: assert property (!$past(SRST) && !$past(SRST, 2) && !$past(SRST, 3)
      |-> $stable(BOD_ACTIVE_MODE) && $stable(BOD_THRESHOLD))
      else $error("brownout setting moved");
   a_window_sw: assert property ($rose(WDOG_WINDOW) |-> $past(WR && ADDR == 4'hA && WDATA[1], 2))
      else $error("window set without write");
endmodule // flc_chk
bind flc_top flc_chk u_chk (.CLK(CLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
   .PM_STORE(PM_STORE), .PM_LOAD(PM_LOAD), .PM_TGT_BOOT(PM_TGT_BOOT),
   .PM_EXEC_BOOT(PM_EXEC_BOOT), .VEC_IN_BOOT(VEC_IN_BOOT), .PM_STORE_OK(PM_STORE_OK),
   .PM_LOAD_OK(PM_LOAD_OK), .INT_MASK(INT_MASK), .ERASE_FLASH(ERASE_FLASH),
   .ERASE_EEPROM(ERASE_EEPROM), .BOD_ACTIVE_MODE(BOD_ACTIVE_MODE),
   .BOD_THRESHOLD(BOD_THRESHOLD), .WDOG_WINDOW(WDOG_WINDOW));
`default_nettype wire

// ===== test/flc_prog.sv
// programmer model: master of the register port
// assumes bench clock, slave never stalls
`timescale 1ns/100ps
`default_nettype none
module flc_prog (
   // bus
   input  wire logic       clk,
   output var  logic [3:0] addr,
   output var  logic [7:0] wdata,
   output var  logic       wr,
   output var  logic       rd,
   input  wire logic [7:0] rdata
);
   initial begin
      {addr, wdata, wr, rd} = 14'h0000;
   end
   task automatic put(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= (a == 4'h5) ? (d | 8'hC0) : (a == 4'h4) ? (d | 8'hE1) : d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic get(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask
endmodule // flc_prog
`default_nettype wire

// ===== test/fuse_lock_config_test.sv
// bench: model of the lock and fuse rules against flc_top
// assumes flc_prog as programmer, short slow tick
`timescale 1ns/100ps
`default_nettype none
module fuse_lock_config_test;
   logic       clk, srst, pm_store, pm_load, tgt, exb, vib, so, lo, im, irst, ef, ee, we, ww;
   logic [3:0] addr;
   logic [7:0] wdata, rdata, d, lk, w;
   logic       wr, rd;
   logic [1:0] bm;
   logic [2:0] bt;
   integer     failures = 0, cmp_count = 0, seed = 32'h0e60, cyc = 0, i;
   flc_prog prog (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
   flc_top #(.SLOW_TICK(18'd4)) uut (.CLK(clk), .SRST(srst), .ADDR(addr), .WDATA(wdata),
      .WR(wr), .RD(rd), .RDATA(rdata), .PM_STORE(pm_store), .PM_LOAD(pm_load),
      .PM_TGT_BOOT(tgt), .PM_EXEC_BOOT(exb), .VEC_IN_BOOT(vib), .PM_STORE_OK(so),
      .PM_LOAD_OK(lo), .INT_MASK(im), .INT_RESET(irst), .BOD_ACTIVE_MODE(bm),
      .BOD_THRESHOLD(bt), .ERASE_FLASH(ef), .ERASE_EEPROM(ee), .WDOG_ENABLE(we),
      .WDOG_WINDOW(ww));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      cmp_count++;
      if (s !== e) begin
         failures++;
         $display("FAIL %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures++;
         conclude;
      end
   end
   // random access request, outputs checked one cycle later
   task automatic pm(input logic [7:0] l);
      @(posedge clk);
      {pm_store, pm_load, tgt, exb, vib} <= 5'($random(seed));
      @(posedge clk);
      @(negedge clk);
      chk("store_ok", so, pm_store && (tgt ? l[6] : l[4]));
      chk("load_ok", lo, pm_load && !(tgt != exb && !(tgt ? l[7] : l[5])));
      chk("int_mask", im, (exb && !vib && !l[7]) || (!exb && vib && !l[5]));
   endtask
   initial begin
      srst = 1'b1;
      {pm_store, pm_load, tgt, exb, vib} = 5'h00;
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      for (i = 0; i < 40 && irst !== 1'b0; i++) @(posedge clk);
      chk("int_reset", irst, 0);
      prog.get(4'h7, d);
      chk("lock", d, 8'hff);
      prog.get(4'h3, d);
      chk("unmapped", d, 8'h00);
      chk("bod_mode", bm, 2'b11);
      chk("bod_thr", bt, 3'h7);
      prog.put(4'h4, 8'hf1);
      prog.get(4'h4, d);
      chk("fuse4", d, 8'hff);
      prog.put(4'ha, 8'h01);
      repeat (2) @(negedge clk);
      chk("wdog_en", we, 1);
      chk("wdog_win", ww, 0);
      prog.put(4'ha, 8'h03);
      repeat (2) @(negedge clk);
      chk("wdog_win_sw", ww, 1);
      chk("wdog_en_sw", we, 1);
      prog.get(4'h9, d);
      chk("status", d & 8'h03, 8'h01);
      $display("test reset and fuses done");
      for (i = 0; i < 2; i++) begin
         prog.put(4'h5, {4'h1, i[0], 3'h2});
         prog.get(4'h5, d);
         chk("fuse5", d, {4'hd, i[0], 3'h2});
         prog.put(4'h8, 8'h01);
         @(negedge clk);
         chk("erase_flash", ef, 1);
         chk("erase_eeprom", ee, i[0]);
         chk("bod_kept", bm, 2'b11);
      end
      $display("test erase done");
      lk = 8'hff;
      for (i = 0; i < 12; i++) begin
         w = 8'($random(seed));
         w = (i == 11) ? 8'hff : {lk[7:4] & w[7:4], lk[3:2], w[1:0]};
         prog.put(4'h7, w);
         if (i != 11) lk = {w[7:4], lk[3:0]};
         prog.get(4'h7, d);
         chk("lock", d, lk);
         repeat (4) pm(lk);
      end
      prog.put(4'h8, 8'h01);
      prog.get(4'h7, d);
      chk("lock_erased", d, 8'hff);
      prog.put(4'h8, 8'h02);
      prog.put(4'h7, 8'hfc);
      prog.get(4'h7, d);
      chk("ext_lock", d, 8'hfc);
      prog.put(4'h8, 8'h01);
      prog.get(4'h7, d);
      chk("ext_erased", d, 8'hff);
      $display("test locks done");
      @(posedge clk);
      srst <= 1'b1;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      for (i = 0; i < 40 && irst !== 1'b0; i++) @(posedge clk);
      chk("int_reset_2", irst, 0);
      prog.get(4'h7, d);
      chk("lock_reset", d, 8'hff);
      chk("bod_mode_2", bm, 2'b11);
      $display("test mid-run reset done");
      conclude;
   end
endmodule // fuse_lock_config_test
`default_nettype wire
